// ---- core/tei_noise_filter.sv ----
// Digital noise filter: passes a new level only after it has been stable long enough.
`timescale 1ns/1ps
module tei_noise_filter (
   input  logic       clk,
   input  logic       arst_n,
   input  logic       pinIn,
   input  logic       tickEn,
   input  logic [7:0] lengthSel,
   output logic       levelOut
);

   typedef struct packed {
      logic       primed;
      logic       sampled;
      logic [7:0] count;
      logic       level;
   } tei_filter_state_type;

   tei_filter_state_type state_reg;
   tei_filter_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.primed = 1'b1;
      // the first edge loads the pin, so reset leaves no false edge.
      if (!state_reg.primed) begin
         state_next.sampled = pinIn;
         state_next.level   = pinIn;
      end else if (tickEn) begin
         state_next.sampled = pinIn;
         if (pinIn != state_reg.sampled) begin
            state_next.count = 8'h00;
         end else if (state_reg.level != state_reg.sampled) begin
            if (state_reg.count + 8'h01 >= lengthSel) begin
               state_next.level = state_reg.sampled;
               state_next.count = 8'h00;
            end else begin
               state_next.count = state_reg.count + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign levelOut = state_reg.primed ? state_reg.level : pinIn;
endmodule

// ---- core/tei_pkg.sv ----
// Package with constants and types shared by the trap and external interrupt logic.
package tei_pkg;

   localparam logic [5:0] EXT_IRQ_CONTROL_ADDR  = 6'h37;
   localparam logic [7:0] EXT_IRQ_CONTROL_RESET = 8'h00;
   localparam int         BIT_IRQ_ONE_FILTER    = 7;
   localparam int         BIT_PIN_ZERO_SELECT   = 6;
   localparam int         BIT_IRQ_FOUR_MODE_HI  = 5;
   localparam int         BIT_IRQ_FOUR_MODE_LO  = 4;
   localparam int         BIT_IRQ_THREE_POL     = 3;
   localparam int         BIT_IRQ_TWO_POL       = 2;
   localparam int         BIT_IRQ_ONE_POL       = 1;

   localparam logic [7:0]  SOFTWARE_TRAP_OPCODE = 8'hFF;
   localparam logic [7:0]  STACK_FRAME_BYTES    = 8'h03;
   localparam logic [15:0] TRAP_AREA_LIMIT      = 16'h0FFF;
   localparam logic [7:0]  SP_RESET             = 8'hFF;

   // Filter lengths are qualifying counts in clock periods.
   localparam logic [7:0] FILT_SHORT_FC   = 8'h02;
   localparam logic [7:0] FILT_MID_FC     = 8'h07;
   localparam logic [7:0] FILT_ONE_FAST   = 8'h0F;
   localparam logic [7:0] FILT_ONE_SLOW   = 8'h3F;
   localparam logic [7:0] FILT_SUB_CLOCK  = 8'h01;

   localparam int FILTER_COUNT = 6;

   typedef enum logic [1:0] {
      TRIG_RISE,
      TRIG_FALL,
      TRIG_BOTH,
      TRIG_HIGH
   } tei_trigger_type;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_PUSH_PSW,
      ST_PUSH_HIGH,
      ST_PUSH_LOW,
      ST_POP_LOW,
      ST_POP_HIGH,
      ST_POP_PSW
   } tei_seq_type;

   // Decide whether a filtered level change, or in TRIG_HIGH mode a high level, counts as a trigger.
   function automatic logic edge_hit(input logic prevLevel, input logic curLevel,
                                     input tei_trigger_type mode);
      logic result;
      result = 1'b0;
      unique case (mode)
         TRIG_RISE: result = !prevLevel && curLevel;
         TRIG_FALL: result = prevLevel && !curLevel;
         TRIG_BOTH: result = prevLevel != curLevel;
         TRIG_HIGH: result = curLevel;
      endcase
      return result;
   endfunction

endpackage

// ---- core/tei_stack_seq.sv ----
// Stack sequencer: pushes the interrupt frame and pops it on return.
`timescale 1ns/1ps
module tei_stack_seq (
   input  logic        clk,
   input  logic        arst_n,
   input  logic        startPush,
   input  logic        startPop,
   input  logic [15:0] pcIn,
   input  logic [7:0]  pswIn,
   input  logic [7:0]  memRdata,
   output logic [7:0]  memAddr,
   output logic [7:0]  memWdata,
   output logic        memWe,
   output logic        memRe,
   output logic [7:0]  spOut,
   output logic [15:0] pcOut,
   output logic [7:0]  pswOut,
   output logic        pushDone,
   output logic        popDone
);

   typedef struct packed {
      tei_pkg::tei_seq_type seq;
      logic [7:0]  sp;
      logic [7:0]  addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
      logic [15:0] pc;
      logic [7:0]  program_status_word;
      logic        pushDone;
      logic        popDone;
   } tei_stack_state_type;

   tei_stack_state_type state_reg;
   tei_stack_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.we = 1'b0;
      state_next.re = 1'b0;
      state_next.pushDone = 1'b0;
      state_next.popDone = 1'b0;
      unique case (state_reg.seq)
         tei_pkg::ST_RUN: begin
            // push frame PROGRAM_STATUS_WORD then PC high then low
            if (startPush) begin
               state_next.pc = pcIn;
               state_next.addr = state_reg.sp;
               state_next.wdata = pswIn;
               state_next.we = 1'b1;
               state_next.seq = tei_pkg::ST_PUSH_PSW;
            end else if (startPop) begin
               // pop low byte first from SP plus one
               state_next.addr = state_reg.sp + 8'h01;
               state_next.re = 1'b1;
               state_next.seq = tei_pkg::ST_POP_LOW;
            end
         end
         tei_pkg::ST_PUSH_PSW: begin
            // high byte lands at final SP plus two
            state_next.addr = state_reg.sp - 8'h01;
            state_next.wdata = state_reg.pc[15:8];
            state_next.we = 1'b1;
            state_next.seq = tei_pkg::ST_PUSH_HIGH;
         end
         tei_pkg::ST_PUSH_HIGH: begin
            // low byte lands at final SP plus one
            state_next.addr = state_reg.sp - 8'h02;
            state_next.wdata = state_reg.pc[7:0];
            state_next.we = 1'b1;
            state_next.seq = tei_pkg::ST_PUSH_LOW;
         end
         tei_pkg::ST_PUSH_LOW: begin
            state_next.sp = state_reg.sp - tei_pkg::STACK_FRAME_BYTES;
            state_next.pushDone = 1'b1;
            state_next.seq = tei_pkg::ST_RUN;
         end
         tei_pkg::ST_POP_LOW: begin
            state_next.pc[7:0] = memRdata;
            state_next.addr = state_reg.sp + 8'h02;
            state_next.re = 1'b1;
            state_next.seq = tei_pkg::ST_POP_HIGH;
         end
         tei_pkg::ST_POP_HIGH: begin
            state_next.pc[15:8] = memRdata;
            state_next.addr = state_reg.sp + 8'h03;
            state_next.re = 1'b1;
            state_next.seq = tei_pkg::ST_POP_PSW;
         end
         tei_pkg::ST_POP_PSW: begin
            // restore status word and raise SP by three
            state_next.program_status_word = memRdata;
            state_next.sp = state_reg.sp + tei_pkg::STACK_FRAME_BYTES;
            state_next.popDone = 1'b1;
            state_next.seq = tei_pkg::ST_RUN;
         end
         default: begin
            state_next.seq = tei_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{seq: tei_pkg::ST_RUN, sp: tei_pkg::SP_RESET, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign memAddr  = state_reg.addr;
   assign memWdata = state_reg.wdata;
   assign memWe    = state_reg.we;
   assign memRe    = state_reg.re;
   assign spOut    = state_reg.sp;
   assign pcOut    = state_reg.pc;
   assign pswOut   = state_reg.program_status_word;
   assign pushDone = state_reg.pushDone;
   assign popDone  = state_reg.popDone;
endmodule

// ---- core/tei_trap_ext_irq.sv ----
// Trap, return-sequence and external interrupt logic of the interrupt control circuit.
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// - Return pops PC and status, SP plus three.
// - Saved low byte SP+1, high byte SP+2.
// - Sample requests in instruction's last cycle.
// - Software trap opcode starts highest-priority interrupt.
// - Nonexistent fetch in single-chip mode returns FF.
// - Fetch from RAM or registers area traps.
// - Trap gives reset or interrupt, watchdog-selected.
// - Undefined opcode raises its interrupt immediately.
// - Undefined opcode interrupt preempts non-maskable service.
// - Address trap interrupt preempts non-maskable service.
// - Six external inputs, each noise filtered.
// - Control bit 6 selects pin zero function.
// - Pin select zero blocks pin zero latch.
// - Inputs zero and five: 2/7 fc filtering.
// - Input one filter 15 or 63 fc.
// - Inputs two to four: 7/25 fc filtering.
// - Low-speed modes filter 1 to 3.5 fs.
// - Clean edge latches within establishment plus 6 fc.
// - Input four mode: rise, fall, both, high.
// - Inputs one to three one-bit polarity select.
// - New input one filter length within 26 fc.
// - High level after reset needs rising edge first.
// - Output changes on shared pins may spuriously request.
// - Accept: clear enable and latch, push, vector; code clears all six latches and fetches no vector.
// - Inputs four, five need shared selector zero.
`timescale 1ns/1ps
module tei_trap_ext_irq (
   clk,
   arst_n,
   regAddr,
   regWdata,
   regWe,
   regRdata,
   extPin,
   port0Bit0In,
   slowMode,
   sharedSourceSelA,
   sharedSourceSelB,
   singleChipMode,
   fetchValid,
   fetchAddr,
   fetchExists,
   fetchData,
   opcodeUndefined,
   lastCycle,
   retOp,
   irqAccept,
   pcIn,
   pswIn,
   watchdogTrapIrqMode,
   memRdata,
   memAddr,
   memWdata,
   memWe,
   memRe,
   spOut,
   pcOut,
   pswOut,
   masterIrqEnable,
   opcodeOut,
   irqLatch,
   softwareIrq,
   undefinedOpcodeIrq,
   addressTrapIrq,
   trapResetOut,
   sampleStrobe,
   returnDone
);
   input  logic        clk;
   input  logic        arst_n;
   input  logic [5:0]  regAddr;
   input  logic [7:0]  regWdata;
   input  logic        regWe;
   output logic [7:0]  regRdata;
   input  logic [5:0]  extPin;
   output logic        port0Bit0In;
   input  logic        slowMode;
   input  logic        sharedSourceSelA;
   input  logic        sharedSourceSelB;
   input  logic        singleChipMode;
   input  logic        fetchValid;
   input  logic [15:0] fetchAddr;
   input  logic        fetchExists;
   input  logic [7:0]  fetchData;
   input  logic        opcodeUndefined;
   input  logic        lastCycle;
   input  logic        retOp;
   input  logic        irqAccept;
   input  logic [15:0] pcIn;
   input  logic [7:0]  pswIn;
   input  logic        watchdogTrapIrqMode;
   input  logic [7:0]  memRdata;
   output logic [7:0]  memAddr;
   output logic [7:0]  memWdata;
   output logic        memWe;
   output logic        memRe;
   output logic [7:0]  spOut;
   output logic [15:0] pcOut;
   output logic [7:0]  pswOut;
   output logic        masterIrqEnable;
   output logic [7:0]  opcodeOut;
   output logic [5:0]  irqLatch;
   output logic        softwareIrq;
   output logic        undefinedOpcodeIrq;
   output logic        addressTrapIrq;
   output logic        trapResetOut;
   output logic        sampleStrobe;
   output logic        returnDone;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl;
      logic [5:0] prevLevel;
      logic       armedFour;
      logic [5:0] latch;
      logic       port0;
      logic       master_irq_enable;
      logic [7:0] opcode;
      logic       swIrq;
      logic       undefIrq;
      logic       trapIrq;
      logic       trapReset;
      logic       sample;
      logic [7:0] rdata;
      logic       retDone;
      logic       warm;
   } tei_top_state_type;

   tei_top_state_type state_reg;
   tei_top_state_type state_next;

   logic [5:0]  filtLevel;
   logic [7:0]  filtLen [tei_pkg::FILTER_COUNT];
   logic        pushDone;
   logic        popDone;
   logic [7:0]  seqPsw;
   logic        trapArea;
   logic [7:0]  fetchedByte;
   tei_pkg::tei_trigger_type fourMode;

   // ----------------------------------------------------------------
   // Noise filters
   // ----------------------------------------------------------------
   // per-input filter lengths
   // length bit read every cycle, so a switch applies at once.
   always_comb begin
      for (int i = 0; i < tei_pkg::FILTER_COUNT; i++) begin
         filtLen[i] = tei_pkg::FILT_MID_FC;
      end
      filtLen[0] = tei_pkg::FILT_SHORT_FC;
      filtLen[5] = tei_pkg::FILT_SHORT_FC;
      filtLen[1] = state_reg.ctrl[tei_pkg::BIT_IRQ_ONE_FILTER] ? tei_pkg::FILT_ONE_FAST
                                                                : tei_pkg::FILT_ONE_SLOW;
      if (slowMode) begin
         for (int i = 0; i < tei_pkg::FILTER_COUNT; i++) begin
            filtLen[i] = tei_pkg::FILT_SUB_CLOCK;
         end
      end
   end

   for (genvar g = 0; g < tei_pkg::FILTER_COUNT; g++) begin : gFilter
      tei_noise_filter uFilter (
         .clk       (clk),
         .arst_n    (arst_n),
         .pinIn     (extPin[g]),
         .tickEn    (1'b1),
         .lengthSel (filtLen[g]),
         .levelOut  (filtLevel[g])
      );
   end

   // ----------------------------------------------------------------
   // Stack sequencer
   // ----------------------------------------------------------------
   tei_stack_seq uStack (
      .clk       (clk),
      .arst_n    (arst_n),
      .startPush (irqAccept),
      .startPop  (retOp),
      .pcIn      (pcIn),
      .pswIn     ({pswIn[7:1], state_reg.master_irq_enable}),
      .memRdata  (memRdata),
      .memAddr   (memAddr),
      .memWdata  (memWdata),
      .memWe     (memWe),
      .memRe     (memRe),
      .spOut     (spOut),
      .pcOut     (pcOut),
      .pswOut    (seqPsw),
      .pushDone  (pushDone),
      .popDone   (popDone)
   );

   // fetch address inside RAM or register area
   assign trapArea = fetchAddr <= tei_pkg::TRAP_AREA_LIMIT;
   // nonexistent memory in single-chip mode reads back the trap opcode
   assign fetchedByte = (singleChipMode && !fetchExists) ? tei_pkg::SOFTWARE_TRAP_OPCODE
                                                         : fetchData;
   assign fourMode = tei_pkg::tei_trigger_type'(state_reg.ctrl[tei_pkg::BIT_IRQ_FOUR_MODE_HI:
                                                               tei_pkg::BIT_IRQ_FOUR_MODE_LO]);

   // ----------------------------------------------------------------
   // Main next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.retDone = popDone;
      state_next.prevLevel = filtLevel;
      state_next.opcode = fetchValid ? fetchedByte : state_reg.opcode;
      state_next.swIrq = 1'b0;
      state_next.undefIrq = 1'b0;
      state_next.trapIrq = 1'b0;
      state_next.trapReset = 1'b0;
      // sample pending requests in last cycle
      state_next.sample = lastCycle;
      // pin zero port path has no masking of output changes
      state_next.port0 = extPin[0];

      if (regWe && regAddr == tei_pkg::EXT_IRQ_CONTROL_ADDR) begin
         state_next.ctrl = {regWdata[7:1], 1'b0};
      end
      state_next.rdata = (regAddr == tei_pkg::EXT_IRQ_CONTROL_ADDR) ? state_reg.ctrl : 8'h00;

      // acceptance clears master enable and latches
      if (irqAccept) begin
         state_next.master_irq_enable = 1'b0;
         state_next.latch = 6'h00;
      end
      // master enable restored with the status word
      if (popDone) begin
         state_next.master_irq_enable = seqPsw[0];
      end

      // pin zero falling edge only when selected
      if (state_reg.ctrl[tei_pkg::BIT_PIN_ZERO_SELECT] &&
          tei_pkg::edge_hit(state_reg.prevLevel[0], filtLevel[0], tei_pkg::TRIG_FALL)) begin
         state_next.latch[0] = 1'b1;
      end
      // one-bit polarity for inputs one to three
      for (int i = 1; i < 4; i++) begin
         if (tei_pkg::edge_hit(state_reg.prevLevel[i], filtLevel[i],
                               tei_pkg::tei_trigger_type'({1'b0, state_reg.ctrl[i]}))) begin
            state_next.latch[i] = 1'b1;
         end
      end
      // high level needs a rising edge after reset
      if (!state_reg.prevLevel[4] && filtLevel[4]) begin
         state_next.armedFour = 1'b1;
      end
      if (!sharedSourceSelA &&
          tei_pkg::edge_hit(state_reg.prevLevel[4], filtLevel[4], fourMode) &&
          (fourMode != tei_pkg::TRIG_HIGH || state_reg.armedFour)) begin
         state_next.latch[4] = 1'b1;
      end
      // input five falling edge only when selected
      if (!sharedSourceSelB &&
          tei_pkg::edge_hit(state_reg.prevLevel[5], filtLevel[5], tei_pkg::TRIG_FALL)) begin
         state_next.latch[5] = 1'b1;
      end

      if (fetchValid) begin
         if (trapArea) begin
            // trap answer chosen by watchdog setting
            state_next.trapIrq = watchdogTrapIrqMode;
            state_next.trapReset = !watchdogTrapIrqMode;
         end else if (fetchedByte == tei_pkg::SOFTWARE_TRAP_OPCODE) begin
            state_next.swIrq = 1'b1;
         end else if (opcodeUndefined) begin
            state_next.undefIrq = 1'b1;
         end
      end
      // no latching until the edge history holds real pin levels.
      state_next.warm = 1'b1;
      if (!state_reg.warm) begin
         state_next.latch     = state_reg.latch;
         state_next.armedFour = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{ctrl: tei_pkg::EXT_IRQ_CONTROL_RESET, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign regRdata           = state_reg.rdata;
   assign port0Bit0In        = state_reg.port0;
   assign masterIrqEnable    = state_reg.master_irq_enable;
   assign opcodeOut          = state_reg.opcode;
   assign irqLatch           = state_reg.latch;
   assign softwareIrq        = state_reg.swIrq;
   assign undefinedOpcodeIrq = state_reg.undefIrq;
   assign addressTrapIrq     = state_reg.trapIrq;
   assign trapResetOut       = state_reg.trapReset;
   assign sampleStrobe       = state_reg.sample;
   assign returnDone         = state_reg.retDone;
   assign pswOut             = seqPsw;
endmodule

// ---- verification/tb_tei_trap_ext_irq.sv ----
// Self-checking bench for the trap and external interrupt logic.
`timescale 1ns/1ps
module tb_tei_trap_ext_irq;
   logic clk = 1'b0, arst_n = 1'b0, regWe, port0Bit0In, slowMode, sharedSourceSelA;
   logic sharedSourceSelB, singleChipMode, fetchValid, fetchExists, opcodeUndefined;
   logic lastCycle, retOp, irqAccept, watchdogTrapIrqMode, memWe, memRe, masterIrqEnable;
   logic softwareIrq, undefinedOpcodeIrq, addressTrapIrq, trapResetOut, sampleStrobe;
   logic returnDone;
   logic [5:0]  regAddr, extPin, irqLatch;
   logic [7:0]  regWdata, regRdata, fetchData, pswIn, memRdata, memAddr, memWdata;
   logic [7:0]  spOut, pswOut, opcodeOut, sp;
   logic [15:0] fetchAddr, pcIn, pcOut;
   int          fail_count = 0;
   int          n_compared = 0;
   int          rej[6] = '{1, 14, 6, 6, 6, 1};
   int          len[6] = '{7, 49, 25, 25, 25, 7};
   tei_trap_ext_irq tei_trap_ext_irq_i (.*);
   tei_stack_mem tei_stack_mem_i (.*);
   always #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWe = 1'b1;
      step(1);
      regWe = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      regAddr = a;
      step(1);
      chk(regRdata, e);
   endtask
   task automatic tog(input int i, input int n);
      extPin[i] = ~extPin[i];
      step(n);
      extPin[i] = ~extPin[i];
   endtask
   task automatic acc();
      irqAccept = 1'b1;
      step(1);
      irqAccept = 1'b0;
      step(5);
      sp = sp - 8'h03;
   endtask
   task automatic ret();
      int k;
      k = 0;
      retOp = 1'b1;
      step(1);
      retOp = 1'b0;
      while (returnDone !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      chk(k < 20, 1'b1);
      sp = sp + 8'h03;
   endtask
   task automatic fet(input logic [15:0] a, input logic ex, input logic [7:0] d,
                      input logic ud);
      step(1);
      fetchValid = 1'b1;
      fetchAddr = a;
      fetchExists = ex;
      fetchData = d;
      opcodeUndefined = ud;
      step(1);
      fetchValid = 1'b0;
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {regWe, slowMode, sharedSourceSelA, sharedSourceSelB, singleChipMode, fetchValid} = '0;
      {fetchExists, opcodeUndefined, lastCycle, retOp, irqAccept, watchdogTrapIrqMode} = '0;
      {regAddr, regWdata, fetchData, pswIn, fetchAddr, pcIn} = '0;
      extPin = 6'h31;
      sp = 8'hFF;
      step(5);
      arst_n = 1'b1;
      step(1);
      chk(spOut, 8'hFF);
      rd(6'h37, 8'h00);
      wr(6'h37, 8'h70);
      step(40);
      chk(irqLatch[4], 1'b0);
      wr(6'h37, 8'hFF);
      rd(6'h37, 8'hFE);
      wr(6'h36, 8'h55);
      rd(6'h37, 8'hFE);
      rd(6'h36, 8'h00);
      extPin[4] = 1'b0;
      step(40);
      for (int m = 0; m < 4; m++) begin
         wr(6'h37, {2'b11, m[1:0], 4'h0});
         step(30);
         acc();
         extPin[4] = 1'b1;
         step(40);
         chk(irqLatch[4], m != 1);
         acc();
         extPin[4] = 1'b0;
         step(40);
         chk(irqLatch[4], m != 0);
         acc();
      end
      wr(6'h37, 8'hC0);
      step(80);
      acc();
      for (int i = 0; i < 6; i++) begin
         tog(i, rej[i]);
         step(80);
         chk(irqLatch[i], 1'b0);
         tog(i, len[i]);
         step(6);
         chk(irqLatch[i], 1'b1);
         step(80);
         acc();
      end
      wr(6'h37, 8'h40);
      step(26);
      tog(1, 62);
      step(80);
      chk(irqLatch[1], 1'b0);
      tog(1, 193);
      step(6);
      chk(irqLatch[1], 1'b1);
      step(80);
      wr(6'h37, 8'hCE);
      step(30);
      acc();
      extPin[3:1] = 3'b111;
      step(80);
      chk(irqLatch[3:1], 3'h0);
      extPin[3:1] = 3'b000;
      step(55);
      chk(irqLatch[3:1], 3'h7);
      wr(6'h37, 8'hC0);
      slowMode = 1'b1;
      step(30);
      acc();
      tog(2, 4);
      step(6);
      chk(irqLatch[2], 1'b1);
      slowMode = 1'b0;
      wr(6'h37, 8'h80);
      step(30);
      acc();
      extPin[0] = 1'b0;
      step(2);
      chk(port0Bit0In, 1'b0);
      step(40);
      chk(irqLatch[0], 1'b0);
      extPin[0] = 1'b1;
      wr(6'h37, 8'hC0);
      {sharedSourceSelA, sharedSourceSelB} = 2'b11;
      step(40);
      acc();
      tog(4, 30);
      tog(5, 30);
      step(40);
      chk(irqLatch[5:4], 2'b00);
      {sharedSourceSelA, sharedSourceSelB} = 2'b00;
      tei_stack_mem_i.mem[sp + 8'h01] = 8'h34;
      tei_stack_mem_i.mem[sp + 8'h02] = 8'h12;
      tei_stack_mem_i.mem[sp + 8'h03] = 8'h01;
      ret();
      chk({pswOut, masterIrqEnable, pcOut}, 32'h00031234);
      chk(spOut, sp);
      pcIn = 16'hABCD;
      pswIn = 8'hA0;
      acc();
      chk({masterIrqEnable, spOut}, {1'b0, sp});
      chk({tei_stack_mem_i.mem[sp + 8'h02], tei_stack_mem_i.mem[sp + 8'h01]}, 16'hABCD);
      chk(tei_stack_mem_i.mem[sp + 8'h03], 8'hA1);
      watchdogTrapIrqMode = 1'b1;
      fet(16'h0040, 1'b1, 8'h00, 1'b0);
      chk(addressTrapIrq, 1'b1);
      acc();
      tei_stack_mem_i.mem[sp + 8'h01] = 8'h00;
      tei_stack_mem_i.mem[sp + 8'h02] = 8'h20;
      ret();
      chk(pcOut, 16'h2000);
      watchdogTrapIrqMode = 1'b0;
      fet(16'h0FFF, 1'b1, 8'h00, 1'b0);
      chk({trapResetOut, addressTrapIrq}, 2'b10);
      singleChipMode = 1'b1;
      fet(16'h8000, 1'b0, 8'h00, 1'b0);
      chk({softwareIrq, opcodeOut}, 9'h1FF);
      fet(16'h1000, 1'b1, 8'hFF, 1'b0);
      chk(softwareIrq, 1'b1);
      fet(16'h1000, 1'b1, 8'h12, 1'b1);
      chk(undefinedOpcodeIrq, 1'b1);
      lastCycle = 1'b1;
      step(1);
      lastCycle = 1'b0;
      chk(sampleStrobe, 1'b1);
      tally_and_finish();
   end
endmodule

// ---- verification/tei_stack_mem.sv ----
// Stack memory model standing on the CPU side of the stack port.
`timescale 1ns/1ps
module tei_stack_mem (
   input wire logic       clk,
   input wire logic [7:0] memAddr,
   input wire logic [7:0] memWdata,
   input wire logic       memWe,
   input wire logic       memRe,
   output logic     [7:0] memRdata
);
   logic [7:0] mem [256];
   // Data stands only while memRe is high; otherwise its inverse shows.
   assign memRdata = memRe ? mem[memAddr] : ~mem[memAddr];
   always @(posedge clk) if (memWe) mem[memAddr] <= memWdata;
endmodule

// ---- verification/tei_trap_ext_irq_chk.sv ----
// Concurrent checks on the ports of the trap and external interrupt logic.
`timescale 1ns/1ps
module tei_trap_ext_irq_chk (
   input logic        clk,
   input logic        arst_n,
   input logic [5:0]  regAddr,
   input logic [7:0]  regWdata,
   input logic        regWe,
   input logic [7:0]  regRdata,
   input logic [5:0]  extPin,
   input logic        fetchValid,
   input logic [15:0] fetchAddr,
   input logic        fetchExists,
   input logic        singleChipMode,
   input logic        lastCycle,
   input logic        retOp,
   input logic        irqAccept,
   input logic [15:0] pcIn,
   input logic [7:0]  pswIn,
   input logic        watchdogTrapIrqMode,
   input logic [7:0]  memAddr,
   input logic [7:0]  memWdata,
   input logic        memWe,
   input logic        memRe,
   input logic [7:0]  spOut,
   input logic        masterIrqEnable,
   input logic [7:0]  opcodeOut,
   input logic [5:0]  irqLatch,
   input logic        softwareIrq,
   input logic        addressTrapIrq,
   input logic        trapResetOut,
   input logic        sampleStrobe
);
   logic [7:0]  spCap;
   logic [7:0]  pswCap;
   logic [15:0] pcCap;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spCap <= 8'hFF;
         pcCap <= 16'h0000;
         pswCap <= 8'h00;
      end else if (irqAccept || retOp) begin
         spCap <= spOut;
         pcCap <= pcIn;
         pswCap <= {pswIn[7:1], masterIrqEnable};
      end
   end
   sequence pushFrame;
      memWe && memAddr == spCap && memWdata == pswCap ##1
      memWe && memAddr == spCap - 8'h01 && memWdata == pcCap[15:8] ##1
      memWe && memAddr == spCap - 8'h02 && memWdata == pcCap[7:0];
   endsequence
   sequence popFrame;
      memRe && memAddr == spCap + 8'h01 ##1 memRe && memAddr == spCap + 8'h02 ##1
      memRe && memAddr == spCap + 8'h03;
   endsequence
   push_frame_a:
      assert property (irqAccept |=> pushFrame ##2 spOut == spCap - 8'h03)
      else $error("push frame wrong");
   pop_frame_a:
      assert property (retOp |=> popFrame ##2 spOut == spCap + 8'h03)
      else $error("pop frame wrong");
   accept_clear_a:
      assert property (irqAccept && !extPin[4] |=> !masterIrqEnable && irqLatch == 6'h00)
      else $error("accept did not clear");
   wr_read_a:
      assert property (regWe && regAddr == 6'h37 ##1 regAddr == 6'h37 && !regWe
         |=> regRdata == ($past(regWdata, 2) & 8'hFE)) else $error("readback wrong");
   trap_irq_a:
      assert property (fetchValid && fetchAddr <= tei_pkg::TRAP_AREA_LIMIT
         && watchdogTrapIrqMode |=> addressTrapIrq && !trapResetOut)
      else $error("trap interrupt missing");
   trap_reset_a:
      assert property (fetchValid && fetchAddr <= tei_pkg::TRAP_AREA_LIMIT
         && !watchdogTrapIrqMode |=> trapResetOut && !addressTrapIrq)
      else $error("trap reset missing");
   missing_fetch_a:
      assert property (fetchValid && singleChipMode && !fetchExists
         && fetchAddr > tei_pkg::TRAP_AREA_LIMIT |=> softwareIrq && opcodeOut == 8'hFF)
      else $error("missing fetch not trapped");
   sample_a:
      assert property (lastCycle |=> sampleStrobe) else $error("no sample strobe");
endmodule
bind tei_trap_ext_irq tei_trap_ext_irq_chk tei_trap_ext_irq_chk_i (.*);
